// ===== src/led_pkg.sv
// Shared constants and types for the front-panel lamp controller
package led_pkg;
  // Clock and timebase
  localparam int unsigned CLOCK_HZ     = 20_000_000;
  localparam int unsigned MS_CYCLES    = CLOCK_HZ / 1000;
  localparam int unsigned RAPID_MS     = 500;
  localparam int unsigned SLOW_MS      = 2000;
  localparam int unsigned BLOCK_MS     = 1000;
  localparam int unsigned RAPID_CYC    = RAPID_MS * MS_CYCLES;
  localparam int unsigned SLOW_CYC     = SLOW_MS * MS_CYCLES;
  localparam int unsigned BLOCK_CYC    = BLOCK_MS * MS_CYCLES;
  localparam int unsigned CNT_W        = 32;
  localparam int unsigned GAIN_W       = 16;
  localparam int unsigned NUM_LAMPS    = 4;
  // Register offsets (byte addresses)
  localparam logic [7:0] OFS_CTRL      = 8'h00;
  localparam logic [7:0] OFS_IN_GAIN   = 8'h04;
  localparam logic [7:0] OFS_MOD_GAIN  = 8'h08;
  localparam logic [7:0] OFS_SERVO_ERR = 8'h0C;
  localparam logic [7:0] OFS_BLOCK     = 8'h10;
  localparam logic [7:0] OFS_BUSY      = 8'h14;
  localparam logic [7:0] OFS_LAMPS     = 8'h18;
  localparam logic [7:0] OFS_IRQ_STAT  = 8'h1C;
  localparam logic [7:0] OFS_IRQ_MASK  = 8'h20;
  // Control register fields
  localparam int unsigned CTRL_W       = 10;
  localparam int unsigned B_BOOT_START = 0;
  localparam int unsigned B_BOOT_DONE  = 1;
  localparam int unsigned B_LINK_UP    = 2;
  localparam int unsigned B_DHCP_EN    = 3;
  localparam int unsigned B_DHCP_OK    = 4;
  localparam int unsigned B_CLIENT     = 5;
  localparam int unsigned B_DEMOD      = 6;
  localparam int unsigned B_AMP_ON     = 7;
  localparam int unsigned B_INPUT_ERR  = 8;
  localparam int unsigned B_MASK_NORM  = 9;
  localparam int unsigned SERR_W       = 12;
  // Interrupt events
  localparam int unsigned IRQ_W        = 4;
  localparam int unsigned EV_SERVO_ERR = 0;
  localparam int unsigned EV_INPUT_ERR = 1;
  localparam int unsigned EV_CLIENT    = 2;
  localparam int unsigned EV_BOOTED    = 3;
  // Lamp indices inside the blinker array
  localparam int unsigned L_NET        = 0;
  localparam int unsigned L_RUN        = 1;
  localparam int unsigned L_INPUT      = 2;
  localparam int unsigned L_SERVO      = 3;
  localparam logic [CNT_W-1:0] CNT_ZERO = 32'h0000_0000;
  localparam logic [CNT_W-1:0] CNT_ONE  = 32'h0000_0001;
  typedef enum logic [1:0] {DARK = 2'b00, LIT = 2'b01, BLINK = 2'b10} lamp_mode_t;
  typedef enum logic [1:0] {ST_POWERON = 2'b00, ST_BOOTING = 2'b01, ST_BOOTED = 2'b10} boot_t;
endpackage

// ===== src/lamp_if.sv
// Carrier between the lamp controller and one blink generator
`timescale 1ns/1ps
interface lamp_if #(parameter int unsigned W = 32);
  led_pkg::lamp_mode_t mode;
  logic [W-1:0]        period;
  logic [W-1:0]        on_time;
  logic                lamp;
  modport ctrl (output mode, output period, output on_time, input lamp);
  modport gen  (input mode, input period, input on_time, output lamp);
endinterface

// ===== src/lamp_blinker.sv
// One lamp: dark, steady or blinking with a given period and on-time
`timescale 1ns/1ps
module lamp_blinker #(
  parameter int unsigned W = 32
) (
  input  wire logic clk_i,    // System clock
  input  wire logic rst_n_i,  // Synchronous reset, active low
  lamp_if.gen       port      // Mode, period and lamp
);
  logic [W-1:0]        cnt_reg, cnt_next;
  logic [W-1:0]        per_reg;
  led_pkg::lamp_mode_t mode_reg;
  logic                lamp_reg, lamp_next;
  logic                restart;

  // Phase restarts on any mode or period change, so blinks start clean
  always_comb
  begin
    restart  = (port.mode != mode_reg) || (port.period != per_reg);
    cnt_next = (restart || (cnt_reg + 1'b1 >= port.period)) ? '0 : cnt_reg + 1'b1;
    case (port.mode)
      led_pkg::LIT:   lamp_next = 1'b1;
      led_pkg::BLINK: lamp_next = (cnt_next < port.on_time);
      default:        lamp_next = 1'b0;
    endcase
  end

  // Registers only
  always_ff @(posedge clk_i)
  begin
    if (!rst_n_i)
    begin
      cnt_reg  <= '0;
      per_reg  <= '0;
      mode_reg <= led_pkg::DARK;
      lamp_reg <= 1'b1;
    end
    else
    begin
      cnt_reg  <= cnt_next;
      per_reg  <= port.period;
      mode_reg <= port.mode;
      lamp_reg <= lamp_next;
    end
  end

  assign port.lamp = lamp_reg;

  chk_blink_restart: assert property (@(posedge clk_i) disable iff (!rst_n_i)
    (port.mode != mode_reg) |=> (cnt_reg == '0))
    else $error("blink phase not restarted on mode change");
  chk_lit_steady: assert property (@(posedge clk_i) disable iff (!rst_n_i)
    (port.mode == led_pkg::LIT) |=> lamp_reg)
    else $error("lit lamp not on");
endmodule // lamp_blinker

// ===== src/status_led_controller.sv
// Front-panel status lamp controller with register port and interrupt
`timescale 1ns/1ps
module status_led_controller #(
  parameter int unsigned CW        = led_pkg::CNT_W,
  parameter int unsigned RAPID_CYC = led_pkg::RAPID_CYC,
  parameter int unsigned SLOW_CYC  = led_pkg::SLOW_CYC,
  parameter int unsigned BLOCK_CYC = led_pkg::BLOCK_CYC
) (
  input  wire logic        CLOCK_I,        // 20 MHz system clock
  input  wire logic        RESET_N_I,      // Synchronous reset, active low
  input  wire logic [7:0]  ADDR_I,         // Register byte address
  input  wire logic [31:0] WDATA_I,        // Write data
  input  wire logic        WR_I,           // Write strobe
  input  wire logic        RD_I,           // Read strobe
  output logic      [31:0] RDATA_O,        // Read data, cycle after strobe
  output logic             IRQ_O,          // Level interrupt
  output logic             POWER_LED_O,    // Power lamp
  output logic             NET_LED_O,      // Network indicator
  output logic             RUN_LED_O,      // Run lamp
  output logic             INPUT_LED_O,    // Optical input lamp
  output logic             SERVO_LED_O     // Servo lamp
);
  localparam int unsigned NL = led_pkg::NUM_LAMPS;
  localparam logic [CW-1:0] RAPID_P = CW'(RAPID_CYC);
  localparam logic [CW-1:0] SLOW_P  = CW'(SLOW_CYC);

  // Software visible state
  logic [led_pkg::CTRL_W-1:0] ctrl_reg, ctrl_next;
  logic [led_pkg::GAIN_W-1:0] in_gain_reg, in_gain_next;
  logic [led_pkg::GAIN_W-1:0] mod_gain_reg, mod_gain_next;
  logic [led_pkg::SERR_W-1:0] serr_reg, serr_next;
  logic [CW-1:0]              block_reg, block_next;
  logic [CW-1:0]              busy_reg, busy_next;
  logic [led_pkg::IRQ_W-1:0]  irq_stat_reg, irq_stat_next;
  logic [led_pkg::IRQ_W-1:0]  irq_mask_reg, irq_mask_next;
  logic [31:0]                rdata_reg, rdata_next;
  logic                       irq_reg, irq_next;
  // Lamp decision state
  led_pkg::boot_t             boot_reg, boot_next;
  led_pkg::lamp_mode_t        mode_reg [NL];
  led_pkg::lamp_mode_t        mode_next [NL];
  logic [CW-1:0]              per_reg [NL];
  logic [CW-1:0]              per_next [NL];
  logic [CW-1:0]              on_reg [NL];
  logic [CW-1:0]              on_next [NL];
  logic [NL:0]                led_reg, led_next;
  logic [led_pkg::IRQ_W-1:0]  ev_prev_reg, ev_now;
  logic                       booted, client, demod, active;
  logic                       servo_err, in_err, gain_in, gain_mod, all_on, any_on;
  logic [CW-1:0]              rapid_p, slow_p;
  logic [NL-1:0]              blink_lamp;

  // Half-period on-time for the status blinks
  function automatic logic [CW-1:0] half(input logic [CW-1:0] p);
    half = p >> 1;
  endfunction

  function automatic logic hit(input logic [7:0] a, input logic [7:0] ofs);
    hit = (a == ofs);
  endfunction

  // Status decode shared by the lamp rules
  always_comb
  begin
    booted    = (boot_reg == led_pkg::ST_BOOTED);
    client    = ctrl_reg[led_pkg::B_CLIENT];
    demod     = ctrl_reg[led_pkg::B_DEMOD] && booted;
    active    = client && demod;
    servo_err = |serr_reg;
    in_err    = ctrl_reg[led_pkg::B_INPUT_ERR];
    gain_in   = |in_gain_reg;
    gain_mod  = |mod_gain_reg;
    all_on    = gain_in && gain_mod && ctrl_reg[led_pkg::B_MASK_NORM];
    any_on    = gain_in || gain_mod || ctrl_reg[led_pkg::B_MASK_NORM];
    // Timebase follows the block interval only when connected and demodulating
    rapid_p   = active ? block_reg : RAPID_P;
    slow_p    = active ? CW'({block_reg, 1'b0}) : SLOW_P;
    ev_now    = '0;
    ev_now[led_pkg::EV_SERVO_ERR] = servo_err && demod;
    ev_now[led_pkg::EV_INPUT_ERR] = in_err && active;
    ev_now[led_pkg::EV_CLIENT]    = client;
    ev_now[led_pkg::EV_BOOTED]    = booted;
  end

  // Boot sequence: power-on lamp test, then booting, then booted
  always_comb
  begin
    boot_next = boot_reg;
    case (boot_reg)
      led_pkg::ST_POWERON:
        if (ctrl_reg[led_pkg::B_BOOT_START]) boot_next = led_pkg::ST_BOOTING;
      led_pkg::ST_BOOTING:
        if (ctrl_reg[led_pkg::B_BOOT_DONE]) boot_next = led_pkg::ST_BOOTED;
      led_pkg::ST_BOOTED:
        boot_next = led_pkg::ST_BOOTED;
      default:
        boot_next = led_pkg::ST_POWERON;
    endcase
  end

  // Lamp modes, periods and on-times
  always_comb
  begin
    for (int i = 0; i < NL; i++)
    begin
      mode_next[i] = led_pkg::DARK;
      per_next[i]  = rapid_p;
      on_next[i]   = half(rapid_p);
    end
    // Network lamp
    if (boot_reg == led_pkg::ST_POWERON)
      mode_next[led_pkg::L_NET] = led_pkg::LIT;
    else if (!booted)
      mode_next[led_pkg::L_NET] = led_pkg::DARK;
    else if (client)
      mode_next[led_pkg::L_NET] = led_pkg::LIT;
    else if (!ctrl_reg[led_pkg::B_LINK_UP] ||
             (ctrl_reg[led_pkg::B_DHCP_EN] && !ctrl_reg[led_pkg::B_DHCP_OK]))
      mode_next[led_pkg::L_NET] = led_pkg::BLINK;
    else
    begin
      mode_next[led_pkg::L_NET] = led_pkg::BLINK;
      per_next[led_pkg::L_NET]  = slow_p;
      on_next[led_pkg::L_NET]   = half(slow_p);
    end
    // Run lamp: period is the block interval, on-time the busy time
    per_next[led_pkg::L_RUN] = block_reg;
    on_next[led_pkg::L_RUN]  = busy_reg;
    if (boot_reg == led_pkg::ST_POWERON)
      mode_next[led_pkg::L_RUN] = led_pkg::LIT;
    else if (demod)
      mode_next[led_pkg::L_RUN] = led_pkg::BLINK;
    else
      mode_next[led_pkg::L_RUN] = led_pkg::DARK;
    // Input lamp; connected but idle has no defined blink, kept dark
    per_next[led_pkg::L_INPUT] = slow_p;
    on_next[led_pkg::L_INPUT]  = half(slow_p);
    if (boot_reg == led_pkg::ST_POWERON)
      mode_next[led_pkg::L_INPUT] = led_pkg::LIT;
    else if (!client && booted)  // nothing but power lit while booting
      mode_next[led_pkg::L_INPUT] = ctrl_reg[led_pkg::B_AMP_ON] ? led_pkg::BLINK
                                                                 : led_pkg::DARK;
    else if (active && in_err)
      mode_next[led_pkg::L_INPUT] = led_pkg::LIT;
    // Servo lamp: error wins over the servo enable pattern
    if (boot_reg == led_pkg::ST_POWERON)
      mode_next[led_pkg::L_SERVO] = led_pkg::LIT;
    else if (!client)
      mode_next[led_pkg::L_SERVO] = led_pkg::DARK;
    else if (active && servo_err)
      mode_next[led_pkg::L_SERVO] = led_pkg::LIT;
    else if (active && all_on)
    begin
      mode_next[led_pkg::L_SERVO] = led_pkg::BLINK;
      per_next[led_pkg::L_SERVO]  = slow_p;
      on_next[led_pkg::L_SERVO]   = half(slow_p);
    end
    else if (active && any_on)
      mode_next[led_pkg::L_SERVO] = led_pkg::BLINK;
    else
      mode_next[led_pkg::L_SERVO] = led_pkg::DARK;
    // Lamp outputs; power stays lit while the clock runs
    led_next = {blink_lamp, 1'b1};
  end

  // Register port: writes, read data and sticky interrupt status
  always_comb
  begin
    ctrl_next     = ctrl_reg;
    in_gain_next  = in_gain_reg;
    mod_gain_next = mod_gain_reg;
    serr_next     = serr_reg;
    block_next    = block_reg;
    busy_next     = busy_reg;
    irq_mask_next = irq_mask_reg;
    rdata_next    = '0;
    if (WR_I)
    begin
      if (hit(ADDR_I, led_pkg::OFS_CTRL))      ctrl_next     = WDATA_I[led_pkg::CTRL_W-1:0];
      if (hit(ADDR_I, led_pkg::OFS_IN_GAIN))   in_gain_next  = WDATA_I[led_pkg::GAIN_W-1:0];
      if (hit(ADDR_I, led_pkg::OFS_MOD_GAIN))  mod_gain_next = WDATA_I[led_pkg::GAIN_W-1:0];
      if (hit(ADDR_I, led_pkg::OFS_SERVO_ERR)) serr_next     = WDATA_I[led_pkg::SERR_W-1:0];
      if (hit(ADDR_I, led_pkg::OFS_BLOCK))     block_next    = WDATA_I[CW-1:0];
      if (hit(ADDR_I, led_pkg::OFS_BUSY))      busy_next     = WDATA_I[CW-1:0];
      if (hit(ADDR_I, led_pkg::OFS_IRQ_MASK))  irq_mask_next = WDATA_I[led_pkg::IRQ_W-1:0];
    end
    if (RD_I)
    begin
      case (ADDR_I)
        led_pkg::OFS_CTRL:      rdata_next = 32'(ctrl_reg);
        led_pkg::OFS_IN_GAIN:   rdata_next = 32'(in_gain_reg);
        led_pkg::OFS_MOD_GAIN:  rdata_next = 32'(mod_gain_reg);
        led_pkg::OFS_SERVO_ERR: rdata_next = 32'(serr_reg);
        led_pkg::OFS_BLOCK:     rdata_next = 32'(block_reg);
        led_pkg::OFS_BUSY:      rdata_next = 32'(busy_reg);
        led_pkg::OFS_LAMPS:     rdata_next = 32'({boot_reg, led_reg});
        led_pkg::OFS_IRQ_STAT:  rdata_next = 32'(irq_stat_reg);
        led_pkg::OFS_IRQ_MASK:  rdata_next = 32'(irq_mask_reg);
        default:                rdata_next = '0;
      endcase
    end
    // Read clears, but a rising event in the same cycle still lands
    irq_stat_next = irq_stat_reg;
    if (RD_I && hit(ADDR_I, led_pkg::OFS_IRQ_STAT))
      irq_stat_next = '0;
    irq_stat_next = irq_stat_next | (ev_now & ~ev_prev_reg);
    irq_next      = |(irq_stat_next & irq_mask_next);
  end

  // All state registers
  always_ff @(posedge CLOCK_I)
  begin
    if (!RESET_N_I)
    begin
      ctrl_reg     <= '0;
      in_gain_reg  <= '0;
      mod_gain_reg <= '0;
      serr_reg     <= '0;
      block_reg    <= CW'(BLOCK_CYC);
      busy_reg     <= '0;
      irq_stat_reg <= '0;
      irq_mask_reg <= '0;
      ev_prev_reg  <= '0;
      rdata_reg    <= '0;
      irq_reg      <= 1'b0;
      boot_reg     <= led_pkg::ST_POWERON;
      led_reg      <= '1;
      for (int i = 0; i < NL; i++)
      begin
        mode_reg[i] <= led_pkg::LIT;
        per_reg[i]  <= CW'(led_pkg::CNT_ONE);
        on_reg[i]   <= CW'(led_pkg::CNT_ZERO);
      end
    end
    else
    begin
      ctrl_reg     <= ctrl_next;
      in_gain_reg  <= in_gain_next;
      mod_gain_reg <= mod_gain_next;
      serr_reg     <= serr_next;
      block_reg    <= block_next;
      busy_reg     <= busy_next;
      irq_stat_reg <= irq_stat_next;
      irq_mask_reg <= irq_mask_next;
      ev_prev_reg  <= ev_now;
      rdata_reg    <= rdata_next;
      irq_reg      <= irq_next;
      boot_reg     <= boot_next;
      led_reg      <= led_next;
      for (int i = 0; i < NL; i++)
      begin
        mode_reg[i] <= mode_next[i];
        per_reg[i]  <= per_next[i];
        on_reg[i]   <= on_next[i];
      end
    end
  end

  // One blink generator per switched lamp
  lamp_if #(.W(CW)) lamp_bus [NL] ();
  for (genvar g = 0; g < NL; g++)
  begin : g_lamp
    assign lamp_bus[g].mode    = mode_reg[g];
    assign lamp_bus[g].period  = per_reg[g];
    assign lamp_bus[g].on_time = on_reg[g];
    assign blink_lamp[g]       = lamp_bus[g].lamp;
    lamp_blinker #(.W(CW)) u_blink (
      .clk_i   (CLOCK_I),
      .rst_n_i (RESET_N_I),
      .port    (lamp_bus[g])
    );
  end

  assign RDATA_O     = rdata_reg;
  assign IRQ_O       = irq_reg;
  assign POWER_LED_O = led_reg[0];
  assign NET_LED_O   = led_reg[1 + led_pkg::L_NET];
  assign RUN_LED_O   = led_reg[1 + led_pkg::L_RUN];
  assign INPUT_LED_O = led_reg[1 + led_pkg::L_INPUT];
  assign SERVO_LED_O = led_reg[1 + led_pkg::L_SERVO];

  default clocking cb @(posedge CLOCK_I); endclocking
  default disable iff (!RESET_N_I);

  sequence s_poweron_hold;
    (boot_reg == led_pkg::ST_POWERON) [*4];
  endsequence
  sequence s_booting_hold;
    (boot_reg == led_pkg::ST_BOOTING) [*4];
  endsequence

  chk_poweron_all_lit: assert property (s_poweron_hold |-> (&led_reg))
    else $error("lamps not all lit at power-on");
  chk_net_boot_dark: assert property (s_booting_hold |-> !NET_LED_O && POWER_LED_O)
    else $error("network lamp lit during boot");
  chk_net_rapid: assert property (booted && !client && !ctrl_reg[led_pkg::B_LINK_UP]
    |=> mode_reg[led_pkg::L_NET] == led_pkg::BLINK && per_reg[led_pkg::L_NET] == RAPID_P)
    else $error("network lamp not rapid without link");
  chk_net_slow: assert property (booted && !client && ctrl_reg[led_pkg::B_LINK_UP]
    && !ctrl_reg[led_pkg::B_DHCP_EN] |=> per_reg[led_pkg::L_NET] == SLOW_P)
    else $error("network lamp not slow when ready");
  chk_run_dark: assert property ((booted && !ctrl_reg[led_pkg::B_DEMOD]) [*4]
    |-> !RUN_LED_O)
    else $error("run lamp lit while idle");
  chk_run_period: assert property (demod |=> per_reg[led_pkg::L_RUN] == $past(block_reg)
    && on_reg[led_pkg::L_RUN] == $past(busy_reg))
    else $error("run lamp timing wrong");
  chk_servo_off: assert property (booted && !client |=> mode_reg[led_pkg::L_SERVO] == led_pkg::DARK)
    else $error("servo lamp on without client");
  chk_servo_err_lit: assert property (active && servo_err
    |=> mode_reg[led_pkg::L_SERVO] == led_pkg::LIT)
    else $error("servo error not shown");
  chk_servo_slow: assert property (active && !servo_err && all_on
    |=> per_reg[led_pkg::L_SERVO] == CW'({$past(block_reg), 1'b0}))
    else $error("servo slow period not twice block");
endmodule // status_led_controller

// ===== verif/lamp_panel.sv
// Front-panel lamp model that times every lamp it is wired to
`timescale 1ns/1ps
module lamp_panel (
  input  wire logic        clk_i,       // System clock
  input  wire logic        rst_n_i,     // Synchronous reset, active low
  input  wire logic [4:0]  lamp_i,      // Lamp levels, bit 0 power .. bit 4 servo
  output logic      [15:0] per_o [5],   // Last rise-to-rise span in cycles
  output logic      [15:0] hi_o [5],    // Last lit span in cycles
  output logic      [15:0] still_o [5]  // Cycles since the last change
);
  logic [4:0]  last_q;   // Level seen at the previous edge
  logic [15:0] run_q [5]; // Cycles since the last rise

  // Edge timing per lamp; a lamp that never rises keeps its old period
  always @(posedge clk_i)
  begin
    last_q <= lamp_i;
    for (int i = 0; i < 5; i++)
    begin
      if (!rst_n_i)
      begin
        per_o[i]   <= 16'h0000;
        hi_o[i]    <= 16'h0000;
        still_o[i] <= 16'h0000;
        run_q[i]   <= 16'h0000;
      end
      else
      begin
        still_o[i] <= (lamp_i[i] != last_q[i]) ? 16'h0000 : still_o[i] + 16'h0001;
        run_q[i]   <= (lamp_i[i] & ~last_q[i]) ? 16'h0001 : run_q[i] + 16'h0001;
        if (lamp_i[i] & ~last_q[i])
          per_o[i] <= run_q[i];
        if (~lamp_i[i] & last_q[i])
          hi_o[i] <= run_q[i];
      end
    end
  end
endmodule // lamp_panel

// ===== verif/status_led_controller_tb_top.sv
// Self-checking bench for the front-panel lamp controller
`timescale 1ns/1ps
module status_led_controller_tb_top;
  localparam int unsigned RAP = 20;  // Shortened rapid period
  localparam int unsigned SLW = 80;  // Shortened slow period
  localparam int unsigned BLK = 40;  // Shortened default block interval
  logic        clk;
  logic        rst_n;
  logic [7:0]  addr;
  logic [31:0] wdata;
  logic        wr;
  logic        rd;
  logic [31:0] rdata;
  logic        irq;
  wire  [4:0]  lamps;      // Bit 0 power .. bit 4 servo
  logic [15:0] per [5];
  logic [15:0] hi [5];
  logic [15:0] still [5];
  logic [15:0] ig;
  logic [15:0] mg;
  int          mismatches = 0;
  int          comparisons = 0;
  int          cycles = 0;
  int unsigned blk;
  int unsigned busy;
  int unsigned sp;

  status_led_controller #(.RAPID_CYC(RAP), .SLOW_CYC(SLW), .BLOCK_CYC(BLK)) dut_u (
    .CLOCK_I(clk), .RESET_N_I(rst_n), .ADDR_I(addr), .WDATA_I(wdata), .WR_I(wr),
    .RD_I(rd), .RDATA_O(rdata), .IRQ_O(irq), .POWER_LED_O(lamps[0]),
    .NET_LED_O(lamps[1]), .RUN_LED_O(lamps[2]), .INPUT_LED_O(lamps[3]),
    .SERVO_LED_O(lamps[4]));
  lamp_panel panel_u (.clk_i(clk), .rst_n_i(rst_n), .lamp_i(lamps), .per_o(per),
    .hi_o(hi), .still_o(still));

  // 20 MHz clock
  initial
  begin
    clk = 1'b0;
    forever #25 clk = ~clk;
  end

  // Hang guard, well above the expected run length
  always @(posedge clk)
  begin
    cycles <= cycles + 1;
    if (cycles == 40000)
    begin
      mismatches++;
      give_verdict();
    end
  end

  task automatic give_verdict();
    if (mismatches == 0 && comparisons > 0)
      $display("verification passed");
    else
      $display("verification failed");
    $finish;
  endtask

  task automatic cmp(input logic [31:0] got, input logic [31:0] exp, input string what);
    comparisons++;
    if (got !== exp)
    begin
      mismatches++;
      $display("unexpected at %0t: %s got %h expected %h", $time, what, got, exp);
    end
  endtask

  // One-cycle write strobe; a gap cycle follows before the next request
  task automatic wreg(input logic [7:0] a, input logic [31:0] v);
    @(posedge clk);
    addr  <= a;
    wdata <= v;
    wr    <= 1'b1;
    @(posedge clk);
    wr    <= 1'b0;
  endtask

  // Read data is only valid in the cycle after the strobe
  task automatic chk_rd(input logic [7:0] a, input logic [31:0] exp);
    logic [31:0] v;
    @(posedge clk);
    addr <= a;
    rd   <= 1'b1;
    @(posedge clk);
    rd   <= 1'b0;
    #1 v = rdata;
    cmp(v, exp, "register read");
  endtask

  // Three periods let any restart settle before the figures are taken
  task automatic blink(input int i, input int unsigned p, input int unsigned on);
    repeat (3 * p + 12) @(posedge clk);
    #1;
    cmp({16'h0000, per[i]}, p, "blink period");
    cmp({16'h0000, hi[i]}, on, "blink on time");
  endtask

  task automatic level(input int i, input logic v);
    repeat (60) @(posedge clk);
    #1;
    cmp({31'h0, lamps[i]}, {31'h0, v}, "lamp level");
    cmp({31'h0, still[i] > 16'h0032}, 32'h1, "lamp stable");
  endtask

  // Servo period: dark with none on, block with some, twice block with all
  function automatic int unsigned servo_per(logic [15:0] a, logic [15:0] b, logic m,
                                            int unsigned t);
    int n;
    n = int'(a != 16'h0000) + int'(b != 16'h0000) + int'(m);
    return (n == 0) ? 0 : (n == 3) ? 2 * t : t;
  endfunction

  // Main sequence
  initial
  begin
    rst_n = 1'b0;
    addr  = 8'h00;
    wdata = 32'h0;
    wr    = 1'b0;
    rd    = 1'b0;
    void'($urandom(32'hC7FA));
    repeat (20) @(posedge clk);
    rst_n <= 1'b1;
    #1 cmp({27'h0, lamps}, 32'h1F, "lamp test");
    @(posedge clk) #1 cmp({27'h0, lamps}, 32'h1F, "lamp test held");
    chk_rd(led_pkg::OFS_BLOCK, BLK);
    chk_rd(led_pkg::OFS_LAMPS, 32'h1F);
    wreg(led_pkg::OFS_IRQ_MASK, 32'h8);
    chk_rd(led_pkg::OFS_IRQ_MASK, 32'h8);
    wreg(led_pkg::OFS_CTRL, 32'h081);  // Amplifier on while booting stays dark
    level(1, 1'b0);
    cmp({27'h0, lamps}, 32'h01, "booting lamps");
    chk_rd(led_pkg::OFS_LAMPS, 32'h21);
    wreg(led_pkg::OFS_CTRL, 32'h003);
    blink(1, RAP, RAP / 2);
    cmp({31'h0, irq}, 32'h1, "irq raised");
    chk_rd(led_pkg::OFS_IRQ_STAT, 32'h8);
    repeat (2) @(posedge clk);
    #1 cmp({31'h0, irq}, 32'h0, "irq cleared");
    chk_rd(led_pkg::OFS_IRQ_STAT, 32'h0);
    wreg(led_pkg::OFS_CTRL, 32'h007);
    blink(1, SLW, SLW / 2);
    wreg(led_pkg::OFS_CTRL, 32'h00F);
    blink(1, RAP, RAP / 2);
    wreg(led_pkg::OFS_CTRL, 32'h09F);
    blink(1, SLW, SLW / 2);
    blink(3, SLW, SLW / 2);
    level(4, 1'b0);
    wreg(led_pkg::OFS_CTRL, 32'h01F);
    level(3, 1'b0);
    wreg(led_pkg::OFS_CTRL, 32'h03F);
    level(1, 1'b1);
    // Every on/off mix of the three servos, random block and busy time
    for (int i = 0; i < 8; i++)
    begin
      blk  = 20 + 2 * ($urandom % 20);
      busy = 1 + $urandom % (blk - 1);
      ig   = i[0] ? 16'($urandom | 1) : 16'h0000;
      mg   = i[1] ? 16'($urandom | 1) : 16'h0000;
      wreg(led_pkg::OFS_BLOCK, blk);
      wreg(led_pkg::OFS_BUSY, busy);
      wreg(led_pkg::OFS_IN_GAIN, {16'h0000, ig});
      wreg(led_pkg::OFS_MOD_GAIN, {16'h0000, mg});
      wreg(led_pkg::OFS_CTRL, 32'h07F | (32'(i[2]) << 9));
      blink(2, blk, busy);
      sp = servo_per(ig, mg, i[2], blk);
      if (sp == 0)
        level(4, 1'b0);
      else
        blink(4, sp, sp / 2);
    end
    chk_rd(led_pkg::OFS_BLOCK, blk);
    wreg(led_pkg::OFS_SERVO_ERR, 32'h1 << ($urandom % 12));
    level(4, 1'b1);
    wreg(led_pkg::OFS_CTRL, 32'h37F);
    level(3, 1'b1);
    wreg(led_pkg::OFS_CTRL, 32'h03F);
    level(2, 1'b0);
    chk_rd(8'hFC, 32'h0);
    give_verdict();
  end
endmodule // status_led_controller_tb_top
